/* logic/dpam_pkg.sv */
// Constants and types for the dual-port memory port controller.
// Assumes one 25 MHz core clock and a device of 128K words of 9 bits.
package dpam_pkg;

   // Device geometry
   localparam int ADDR_W = 17;
   localparam int DATA_W = 9;
   localparam int TOKEN_ADDR_W = 3;
   localparam int TOKEN_COUNT = 8;

   // Mailbox words at the top of the array
   localparam logic [ADDR_W-1:0] MBOX_RIGHT_ADDR = 17'h1FFFF;
   localparam logic [ADDR_W-1:0] MBOX_LEFT_ADDR  = 17'h1FFFE;

   // Clock and pin timing, in ns
   localparam int CLK_PERIOD_NS = 40;
   localparam int ACCESS_NS = 20;
   localparam int BUSY_SETTLE_NS = 20;
   localparam int TOKEN_UPDATE_GAP_NS = 10;
   localparam int WRITE_PULSE_NS = 40;
   localparam int SYNC_STAGES = 2;

   // Cycle counts: least times round up, none below one cycle
   localparam logic [3:0] ACCESS_CYC =
      4'((ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES);
   localparam logic [3:0] BUSY_SETTLE_CYC =
      4'((BUSY_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES);
   localparam logic [3:0] GAP_CYC =
      4'((TOKEN_UPDATE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] WRITE_PULSE_CYC =
      4'((WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0] TOKEN_POLL_MAX = 8'h10;

   // Token values on data bit zero
   localparam logic TOKEN_REQUEST = 1'b0;
   localparam logic TOKEN_RELEASE = 1'b1;

   typedef enum logic [2:0] {
      CMD_MEM_READ   = 3'h0,
      CMD_MEM_WRITE  = 3'h1,
      CMD_TOKEN_TAKE = 3'h2,
      CMD_TOKEN_GIVE = 3'h3,
      CMD_TOKEN_READ = 3'h4
   } dpam_cmd_e;

   typedef struct packed {
      dpam_cmd_e         kind;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } dpam_cmd_s;

   typedef struct packed {
      logic              ce_n;
      logic              rw_n;
      logic              oe_n;
      logic              token_latch_select_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data_out;
      logic              data_oe_n;
   } dpam_pins_s;

   localparam dpam_pins_s PINS_IDLE = '{
      ce_n: 1'b1, rw_n: 1'b1, oe_n: 1'b1, token_latch_select_n: 1'b1,
      addr: '0, data_out: '0, data_oe_n: 1'b1};

endpackage

/* logic/dpam_sync.sv */
// Two-stage synchroniser for pin inputs.
// Assumes inputs come from outside the core clock domain.
`timescale 1ns/10ps
module dpam_sync #(
   parameter int W = 1
) (
   input  wire logic         core_clk,
   input  wire logic         srst,
   input  wire logic [W-1:0] async_in,
   input  wire logic [W-1:0] rst_val,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_q;

   // First stage feeds only the second stage
   always_ff @(posedge core_clk) begin
      if (srst) begin
         meta_q   <= rst_val;
         sync_out <= rst_val;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule

/* logic/dpam_port_ctrl.sv */
// Controller for one port of an asynchronous dual-port memory.
// Assumes the device pins are wired directly; busy, interrupt and data
// inputs are asynchronous and are synchronised here.
`timescale 1ns/10ps
module dpam_port_ctrl (
   input  wire logic                        core_clk,
   input  wire logic                        srst,
   // User command side
   input  wire logic                        cmd_valid,
   input  wire dpam_pkg::dpam_cmd_s         cmd,
   output logic                             cmd_ready,
   output logic                             resp_valid,
   output logic [dpam_pkg::DATA_W-1:0]      resp_data,
   output logic                             resp_token_owned,
   output logic                             mbox_irq,
   output logic                             busy_seen,
   // Device pins
   output dpam_pkg::dpam_pins_s             pins,
   input  wire logic [dpam_pkg::DATA_W-1:0] data_in,
   input  wire logic                        busy_n,
   input  wire logic                        int_n
);

   typedef enum logic [6:0] {
      ST_IDLE    = 7'h01,
      ST_SELECT  = 7'h02,
      ST_STROBE  = 7'h04,
      ST_RELEASE = 7'h08,
      ST_GAP     = 7'h10,
      ST_WAIT_RD = 7'h20,
      ST_DONE    = 7'h40
   } dpam_state_e;

   localparam int SYNC_W = dpam_pkg::DATA_W + 2;

   dpam_state_e                  state_q;
   dpam_pkg::dpam_cmd_s          cmd_q;
   dpam_pkg::dpam_pins_s         pins_q;
   logic [3:0]                   cnt_q;
   logic [7:0]                   poll_q;
   logic [SYNC_W-1:0]            sync_vec;
   logic [dpam_pkg::DATA_W-1:0]  din_s;
   logic                         busy_s_n;
   logic                         int_s_n;
   logic                         is_write;
   logic                         is_token;
   logic                         cnt_zero;

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisation

   dpam_sync #(
      .W (SYNC_W)
   ) u_sync (
      .core_clk (core_clk),
      .srst     (srst),
      .async_in ({busy_n, int_n, data_in}),
      .rst_val  ('1),
      .sync_out (sync_vec)
   );

   assign busy_s_n = sync_vec[SYNC_W-1];
   assign int_s_n  = sync_vec[SYNC_W-2];
   assign din_s    = sync_vec[dpam_pkg::DATA_W-1:0];

   // Command decode
   assign is_write = (cmd_q.kind == dpam_pkg::CMD_MEM_WRITE) ||
                     (cmd_q.kind == dpam_pkg::CMD_TOKEN_TAKE) ||
                     (cmd_q.kind == dpam_pkg::CMD_TOKEN_GIVE);
   assign is_token = (cmd_q.kind == dpam_pkg::CMD_TOKEN_TAKE) ||
                     (cmd_q.kind == dpam_pkg::CMD_TOKEN_GIVE) ||
                     (cmd_q.kind == dpam_pkg::CMD_TOKEN_READ);
   assign cnt_zero = (cnt_q == 4'h0);

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer and pin drive

   always_ff @(posedge core_clk) begin
      if (srst) begin
         state_q <= ST_IDLE;
         cmd_q   <= '0;
         pins_q  <= dpam_pkg::PINS_IDLE;
         cnt_q   <= 4'h0;
         poll_q  <= 8'h00;
      end else begin
         if (!cnt_zero) begin
            cnt_q <= cnt_q - 4'h1;
         end
         case (state_q)
            ST_IDLE: begin
               if (cmd_valid) begin
                  cmd_q  <= cmd;
                  poll_q <= dpam_pkg::TOKEN_POLL_MAX;
                  cnt_q  <= dpam_pkg::BUSY_SETTLE_CYC;
                  state_q <= ST_SELECT;
                  pins_q.rw_n <= 1'b1;
                  if ((cmd.kind == dpam_pkg::CMD_MEM_READ) ||
                      (cmd.kind == dpam_pkg::CMD_MEM_WRITE)) begin
                     pins_q.ce_n <= 1'b0;
                     pins_q.token_latch_select_n <= 1'b1;
                     pins_q.addr <= cmd.addr;
                  end else begin
                     pins_q.ce_n <= 1'b1;
                     pins_q.token_latch_select_n <= 1'b0;
                     pins_q.addr <= {{(dpam_pkg::ADDR_W-dpam_pkg::TOKEN_ADDR_W){1'b0}},
                                     cmd.addr[dpam_pkg::TOKEN_ADDR_W-1:0]};
                  end
                  if (cmd.kind == dpam_pkg::CMD_MEM_READ ||
                      cmd.kind == dpam_pkg::CMD_TOKEN_READ) begin
                     // output enable with the chosen select
                     pins_q.oe_n <= 1'b0;
                     pins_q.data_oe_n <= 1'b1;
                  end else begin
                     pins_q.oe_n <= 1'b1;
                     pins_q.data_oe_n <= 1'b0;
                     if (cmd.kind == dpam_pkg::CMD_TOKEN_TAKE) begin
                        pins_q.data_out <= {{(dpam_pkg::DATA_W-1){1'b1}},
                                            dpam_pkg::TOKEN_REQUEST};
                     end else if (cmd.kind == dpam_pkg::CMD_TOKEN_GIVE) begin
                        pins_q.data_out <= {dpam_pkg::DATA_W{dpam_pkg::TOKEN_RELEASE}};
                     end else begin
                        pins_q.data_out <= cmd.wdata;
                     end
                  end
               end
            end
            ST_SELECT: begin
               // wait for busy to settle and, on array accesses, clear
               if (cnt_zero && (is_token || busy_s_n)) begin
                  if (is_write) begin
                     pins_q.rw_n <= 1'b0;
                     cnt_q <= dpam_pkg::WRITE_PULSE_CYC;
                     state_q <= ST_STROBE;
                  end else begin
                     cnt_q <= dpam_pkg::ACCESS_CYC;
                     state_q <= ST_WAIT_RD;
                  end
               end
            end
            ST_STROBE: begin
               // end strobe when the write pulse count runs out, busy or not; release checks busy
               if (cnt_zero) begin
                  pins_q.rw_n <= 1'b1;
                  state_q <= ST_RELEASE;
               end
            end
            ST_RELEASE: begin
               pins_q.ce_n <= 1'b1;
               pins_q.token_latch_select_n <= 1'b1;
               pins_q.data_oe_n <= 1'b1;
               if (!is_token && !busy_s_n) begin
                  // Busy arrived during the write: repeat it
                  pins_q.ce_n <= 1'b0;
                  pins_q.data_oe_n <= 1'b0;
                  cnt_q <= dpam_pkg::BUSY_SETTLE_CYC;
                  state_q <= ST_SELECT;
               end else if (cmd_q.kind == dpam_pkg::CMD_TOKEN_TAKE) begin
                  cnt_q <= dpam_pkg::GAP_CYC;
                  state_q <= ST_GAP;
               end else begin
                  state_q <= ST_DONE;
               end
            end
            ST_GAP: begin
               if (cnt_zero) begin
                  pins_q.token_latch_select_n <= 1'b0;
                  pins_q.oe_n <= 1'b0;
                  cnt_q <= dpam_pkg::ACCESS_CYC;
                  state_q <= ST_WAIT_RD;
               end
            end
            ST_WAIT_RD: begin
               if (cnt_zero) begin
                  if (!is_token && !busy_s_n) begin
                     // Lost arbitration: data not valid yet
                     cnt_q <= dpam_pkg::ACCESS_CYC;
                  end else begin
                     pins_q.ce_n <= 1'b1;
                     pins_q.token_latch_select_n <= 1'b1;
                     pins_q.oe_n <= 1'b1;
                     // keep polling while the other side holds it, up to TOKEN_POLL_MAX retries
                     if (cmd_q.kind == dpam_pkg::CMD_TOKEN_TAKE &&
                         din_s[0] != dpam_pkg::TOKEN_REQUEST &&
                         poll_q != 8'h00) begin
                        poll_q <= poll_q - 8'h01;
                        cnt_q <= dpam_pkg::GAP_CYC;
                        state_q <= ST_GAP;
                     end else begin
                        state_q <= ST_DONE;
                     end
                  end
               end
            end
            ST_DONE: begin
               state_q <= ST_IDLE;
            end
            default: begin
               state_q <= ST_IDLE;
               pins_q <= dpam_pkg::PINS_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Response and status registers

   always_ff @(posedge core_clk) begin
      if (srst) begin
         resp_valid       <= 1'b0;
         resp_data        <= '0;
         resp_token_owned <= 1'b0;
      end else begin
         resp_valid <= (state_q == ST_DONE);
         if (state_q == ST_WAIT_RD && cnt_zero && (is_token || busy_s_n)) begin
            resp_data <= din_s;
            // zero on bit zero means this side holds it
            resp_token_owned <= is_token && (din_s[0] == dpam_pkg::TOKEN_REQUEST);
         end else if (state_q == ST_IDLE && cmd_valid) begin
            resp_data        <= '0;
            resp_token_owned <= 1'b0;
         end
      end
   end

   // Ready, interrupt level and busy level
   always_ff @(posedge core_clk) begin
      if (srst) begin
         cmd_ready <= 1'b0;
         mbox_irq  <= 1'b0;
         busy_seen <= 1'b0;
      end else begin
         cmd_ready <= (state_q == ST_IDLE) && !cmd_valid;
         mbox_irq  <= !int_s_n;
         busy_seen <= !busy_s_n;
      end
   end

   assign pins = pins_q;

endmodule

/* verif/dpam_port_ctrl_checker.sv */
// Pin and handshake assertions for the port controller.
// Assumes bind onto dpam_port_ctrl; one clock, sync reset.
`timescale 1ns/10ps
module dpam_port_ctrl_checker (
   input wire logic                        core_clk,
   input wire logic                        srst,
   input wire logic                        cmd_valid,
   input wire dpam_pkg::dpam_cmd_s         cmd,
   input wire logic                        cmd_ready,
   input wire logic                        resp_valid,
   input wire logic [dpam_pkg::DATA_W-1:0] resp_data,
   input wire logic                        resp_token_owned,
   input wire logic                        mbox_irq,
   input wire logic                        busy_seen,
   input wire dpam_pkg::dpam_pins_s        pins,
   input wire logic [dpam_pkg::DATA_W-1:0] data_in,
   input wire logic                        busy_n,
   input wire logic                        int_n
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   ////////////////////////////////////////////////////////////////////////
   // Select and strobe relations
   a_sel_exclusive: assert property (!(!pins.ce_n && !pins.token_latch_select_n))
      else $error("array and token selects low together");
   a_read_pair: assert property (!pins.oe_n |-> (!pins.ce_n || !pins.token_latch_select_n))
      else $error("output enable without a select");
   a_write_framed: assert property (
      !pins.rw_n |-> !pins.data_oe_n && (!pins.ce_n || !pins.token_latch_select_n))
      else $error("write strobe without select or data");
   a_write_addr_stable: assert property (!pins.rw_n ##1 !pins.rw_n |-> $stable(pins.addr))
      else $error("address moved during write strobe");
   a_no_write_busy: assert property ($fell(pins.rw_n) |-> !busy_seen)
      else $error("write strobe started while busy");
   a_token_addr: assert property (
      !pins.token_latch_select_n |-> pins.addr[dpam_pkg::ADDR_W-1:dpam_pkg::TOKEN_ADDR_W] == '0)
      else $error("upper address bits set on token access");
   a_token_gap: assert property (
      $rose(pins.rw_n) && !pins.token_latch_select_n |=> pins.token_latch_select_n [*2])
      else $error("token read without update gap");

   ////////////////////////////////////////////////////////////////////////
   // User side handshake and status
   a_resp_pulse: assert property (resp_valid |=> !resp_valid)
      else $error("response longer than one cycle");
   a_ready_drop: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
      else $error("ready stayed high after command taken");
   a_irq_follow: assert property (!int_n [*5] |-> mbox_irq)
      else $error("interrupt status not following pin");
   a_busy_follow: assert property (!busy_n [*5] |-> busy_seen)
      else $error("busy status not following pin");
endmodule

bind dpam_port_ctrl dpam_port_ctrl_checker i_chk (
   .core_clk(core_clk), .srst(srst), .cmd_valid(cmd_valid), .cmd(cmd),
   .cmd_ready(cmd_ready), .resp_valid(resp_valid), .resp_data(resp_data),
   .resp_token_owned(resp_token_owned), .mbox_irq(mbox_irq), .busy_seen(busy_seen),
   .pins(pins), .data_in(data_in), .busy_n(busy_n), .int_n(int_n));

/* verif/dpam_dev_model.sv */
// Behavioural dual-port memory seen from the controller's port (left).
// Assumes the far port is played by the bench through tok_write and far_mbox.
`timescale 1ns/10ps
module dpam_dev_model (
   input  wire logic                        core_clk,
   input  wire dpam_pkg::dpam_pins_s        pins,
   input  wire logic                        busy_hold,
   output logic [dpam_pkg::DATA_W-1:0]      data_in,
   output logic                             busy_n,
   output logic                             int_n
);
   logic [8:0] mem [int];
   int         state [8];   // 0 free, 1 near side holds, 2 far side holds
   bit         pend [1:2][8];
   logic       rd_on;

   initial begin
      foreach (state[i]) state[i] = 0;
      int_n = 1'b1;
      data_in = '0;
      rd_on = 1'b0;
   end

   assign busy_n = ~busy_hold;

   task automatic tok_write(input int side, input int i, input logic v);
      if (v == 1'b0 && state[i] == 0) state[i] = side;
      else if (v == 1'b0 && state[i] != side) pend[side][i] = 1'b1;
      else if (v == 1'b1 && state[i] == side) begin
         state[i] = pend[3-side][i] ? 3 - side : 0;
         pend[3-side][i] = 1'b0;
      end else if (v == 1'b1) pend[side][i] = 1'b0;
   endtask

   function automatic logic tok_view(input int side, input int i);
      return (state[i] == side) ? 1'b0 : 1'b1;
   endfunction

   // far side fills its message and raises interrupt
   task automatic far_mbox(input logic [8:0] d);
      mem[dpam_pkg::MBOX_LEFT_ADDR] = d;
      int_n <= 1'b0;
   endtask

   always @(posedge pins.rw_n) begin
      if (!pins.ce_n && busy_n) mem[pins.addr] = pins.data_out;
      else if (!pins.token_latch_select_n) tok_write(1, pins.addr[2:0], pins.data_out[0]);
   end

   // read data, latched token value, mailbox clear
   always @(posedge core_clk) begin
      rd_on <= !pins.oe_n;
      if (!pins.oe_n && !pins.ce_n) begin
         data_in <= mem.exists(pins.addr) ? mem[pins.addr] : 9'h000;
         if (pins.addr == dpam_pkg::MBOX_LEFT_ADDR && busy_n) int_n <= 1'b1;
      end else if (!pins.oe_n && !pins.token_latch_select_n) begin
         if (!rd_on) data_in <= {9{tok_view(1, pins.addr[2:0])}};
      end else data_in <= ~data_in;
   end
endmodule

/* verif/dpam_port_ctrl_tb_top.sv */
// Self-checking bench: command sequences with expected results.
// Assumes the device model stands on the pins and plays the far port.
`timescale 1ns/10ps
module dpam_port_ctrl_tb_top;
   logic                core_clk;
   logic                srst;
   logic                cmd_valid;
   logic                busy_hold;
   dpam_pkg::dpam_cmd_s cmd;
   logic                cmd_ready;
   logic                resp_valid;
   logic                resp_token_owned;
   logic                mbox_irq;
   logic                busy_seen;
   logic                busy_n;
   logic                int_n;
   logic [8:0]          resp_data;
   logic [8:0]          data_in;
   logic [8:0]          rd;
   logic                own;
   dpam_pkg::dpam_pins_s pins;
   int                  miscompares;
   int                  compares;

   dpam_port_ctrl i_dut (.core_clk(core_clk), .srst(srst), .cmd_valid(cmd_valid),
      .cmd(cmd), .cmd_ready(cmd_ready), .resp_valid(resp_valid), .resp_data(resp_data),
      .resp_token_owned(resp_token_owned), .mbox_irq(mbox_irq), .busy_seen(busy_seen),
      .pins(pins), .data_in(data_in), .busy_n(busy_n), .int_n(int_n));
   dpam_dev_model i_dev (.core_clk(core_clk), .pins(pins), .busy_hold(busy_hold),
      .data_in(data_in), .busy_n(busy_n), .int_n(int_n));

   // Clock at 25 MHz
   always #20 core_clk = ~core_clk;

   ////////////////////////////////////////////////////////////////////////
   // Comparison, command and closing tasks
   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic test_done();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic run(input dpam_pkg::dpam_cmd_e k, input logic [16:0] a, input logic [8:0] d);
      int n;
      @(negedge core_clk);
      cmd = '{kind: k, addr: a, wdata: d};
      cmd_valid = 1'b1;
      @(negedge core_clk);
      cmd_valid = 1'b0;
      n = 0;
      while (resp_valid !== 1'b1 && n < 2000) begin
         @(negedge core_clk);
         n++;
      end
      if (n == 2000) begin
         miscompares++;
         test_done();
      end
      rd = resp_data;
      own = resp_token_owned;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      core_clk = 1'b0;
      srst = 1'b1;
      cmd_valid = 1'b0;
      busy_hold = 1'b0;
      cmd = '0;
      miscompares = 0;
      compares = 0;
      repeat (2) @(negedge core_clk);
      srst = 1'b0;
      repeat (3) @(negedge core_clk);
      // Array writes back to back, then read back
      run(dpam_pkg::CMD_MEM_WRITE, 17'h00005, 9'h1A5);
      check(rd, 9'h000);
      run(dpam_pkg::CMD_MEM_WRITE, 17'h00006, 9'h05A);
      run(dpam_pkg::CMD_MEM_READ, 17'h00005, 9'h000);
      check(rd, 9'h1A5);
      run(dpam_pkg::CMD_MEM_READ, 17'h00006, 9'h000);
      check(rd, 9'h05A);
      // All latches free, upper address ignored
      for (int i = 0; i < 8; i++) begin
         run(dpam_pkg::CMD_TOKEN_READ, {14'h3FFF, 3'(i)}, 9'h000);
         check(rd, 9'h1FF);
      end
      // Free latch taken, far side sees it held
      run(dpam_pkg::CMD_TOKEN_TAKE, 17'h00003, 9'h000);
      check({8'h00, own}, 9'h001);
      check(rd, 9'h000);
      check({8'h00, i_dev.tok_view(2, 3)}, 9'h001);
      run(dpam_pkg::CMD_TOKEN_GIVE, 17'h00003, 9'h000);
      run(dpam_pkg::CMD_TOKEN_READ, 17'h00003, 9'h000);
      check(rd, 9'h1FF);
      // Far side holds latch 5: polling fails, request stays pending
      i_dev.tok_write(2, 5, 1'b0);
      run(dpam_pkg::CMD_TOKEN_TAKE, 17'h00005, 9'h000);
      check({8'h00, own}, 9'h000);
      check(rd, 9'h1FF);
      i_dev.tok_write(2, 5, 1'b1);
      run(dpam_pkg::CMD_TOKEN_READ, 17'h00005, 9'h000);
      check(rd, 9'h000);
      run(dpam_pkg::CMD_TOKEN_GIVE, 17'h00005, 9'h000);
      check({8'h00, i_dev.tok_view(2, 5)}, 9'h001);
      // Mailbox interrupt: raise, read other word, clear by own read
      i_dev.far_mbox(9'h0C3);
      repeat (6) @(negedge core_clk);
      check({8'h00, mbox_irq}, 9'h001);
      run(dpam_pkg::CMD_MEM_READ, dpam_pkg::MBOX_RIGHT_ADDR, 9'h000);
      repeat (6) @(negedge core_clk);
      check({8'h00, mbox_irq}, 9'h001);
      run(dpam_pkg::CMD_MEM_READ, dpam_pkg::MBOX_LEFT_ADDR, 9'h000);
      check(rd, 9'h0C3);
      repeat (6) @(negedge core_clk);
      check({8'h00, mbox_irq}, 9'h000);
      // Write held off while busy, completes after release
      busy_hold = 1'b1;
      repeat (8) @(negedge core_clk);
      fork
         run(dpam_pkg::CMD_MEM_WRITE, 17'h00009, 9'h133);
         begin
            repeat (40) @(negedge core_clk);
            check({8'h00, pins.rw_n}, 9'h001);
            check({8'h00, resp_valid}, 9'h000);
            check({8'h00, busy_seen}, 9'h001);
            busy_hold = 1'b0;
         end
      join
      run(dpam_pkg::CMD_MEM_READ, 17'h00009, 9'h000);
      check(rd, 9'h133);
      test_done();
   end
endmodule
